// ===== rtl/prmc_pkg.sv
package prmc_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CMD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
  localparam logic [7:0] WAKE_EN_OFS = 8'h14;
  localparam logic [7:0] WAKE_FLAG_OFS = 8'h18;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int CTRL_RDYEN_BIT = 1;
  localparam int CTRL_RDYPOL_BIT = 2;
  localparam int CMD_IDLE_BIT = 0;
  localparam int CMD_POWER_DOWN_INSTRUCTION_BIT = 1;
  localparam int EV_IDLE_IN = 0;
  localparam int EV_PD_IN = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_REFUSE = 3;
  localparam int EV_NUM = 4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] WAKE_EN_RST = 8'h00;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int WAKE_MIN_NS = 40;
  localparam int WAKE_MIN_CYC = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PLL_LOCK_WAIT_CYC = 16;

  typedef enum logic [2:0] {
    PRMC_RUN,
    PRMC_DRAIN,
    PRMC_IDLE,
    PRMC_PD_PROT,
    PRMC_PD_INT,
    PRMC_RESTART
  } prmc_state_t;
endpackage : prmc_pkg

// ===== rtl/prmc_sync.sv
`timescale 1ns/10ps
module prmc_sync #(
  parameter int WIDTH = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // Two-flop synchroniser; stage1 feeds only sync_out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : prmc_sync

// ===== rtl/prmc_pulse_filter.sv
`timescale 1ns/10ps
module prmc_pulse_filter #(
  parameter int WIDTH = 8,
  parameter int MIN_CYC = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] qualified
);
  localparam int CW = $clog2(MIN_CYC + 1);
  logic [CW-1:0] cnt [WIDTH];
  logic [CW-1:0] next_cnt [WIDTH];
  logic [WIDTH-1:0] next_qualified;

  // Count consecutive high cycles per pin
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (!level_in[i]) begin
        next_cnt[i] = '0;
      end else if (cnt[i] != CW'(MIN_CYC)) begin
        next_cnt[i] = cnt[i] + CW'(1);
      end else begin
        next_cnt[i] = cnt[i];
      end
      next_qualified[i] = level_in[i] && (cnt[i] >= CW'(MIN_CYC - 1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < WIDTH; i++) begin
        cnt[i] <= '0;
      end
      qualified <= '0;
    end else begin
      cnt <= next_cnt;
      qualified <= next_qualified;
    end
  end
endmodule : prmc_pulse_filter

// ===== rtl/prmc_ctrl.sv
// Overview of operation
// R1 - Idle or power down is entered only after software writes an entry command.
// R2 - In idle the core clock is gated off while the peripheral clock keeps running.
// R3 - Idle ends on any reset or any interrupt request.
// R4 - In power down both the core and the peripheral clocks are gated off.
// R5 - Power down ends only by hardware reset or a fast wake-up pin, per the selected variant.
// R6 - With the variant bit at 0 the protected variant is used and only reset ends it.
// R7 - In the protected variant entry happens only if the synchronised NMI pin is still low.
// R8 - With the variant bit set, clocks are frozen and oscillator and PLL are stopped.
// R9 - A wake-up pin must be high for at least 40 ns and is then recognised.
// R10 - A recognised wake-up restarts oscillator and PLL and turns on the weak pulldown.
// R11 - An enabled waking interrupt is raised to the core for service before resuming.
// R12 - A disabled waking interrupt leaves its request flag set until software clears it.
// R13 - Entry waits until no external bus action is pending.
// R14 - Entry is refused when ready is enabled but was not active on the last bus access.
// R15 - Wake-up pins and NMI pass a two-flop synchroniser before use.
// R16 - The core restart is held off until the PLL reports lock.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module prmc_ctrl
  import prmc_pkg::*;
#(
  parameter int NPINS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPINS-1:0] wake_pin,
  input wire logic nmi_n_pin,
  input wire logic irq_request,
  input wire logic bus_busy,
  input wire logic ready_seen,
  input wire logic pll_locked,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic pll_en,
  output logic weak_pulldown_en,
  output logic [NPINS-1:0] wake_irq,
  output logic irq
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  prmc_state_t state, next_state;
  logic [2:0] ctrl, next_ctrl;
  logic [NPINS-1:0] wake_en, next_wake_en;
  logic [NPINS-1:0] wake_flag, next_wake_flag;
  logic [EV_NUM-1:0] irq_stat, next_irq_stat;
  logic [EV_NUM-1:0] irq_mask, next_irq_mask;
  logic pend_pd, next_pend_pd;
  logic [7:0] lock_cnt, next_lock_cnt;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [NPINS:0] sync_all;
  logic [NPINS-1:0] wake_q;
  logic nmi_low;
  logic wr_acc, rd_acc, setup;
  logic cmd_idle, cmd_pd, ready_ok, any_wake;
  logic [EV_NUM-1:0] ev;

  // ----------------------------------------
  // Pin conditioning
  // ----------------------------------------
  prmc_sync #(.WIDTH(NPINS + 1)) u_sync ( // [R15]
    .pclk(pclk),
    .presetn(presetn),
    .async_in({~nmi_n_pin, wake_pin}),
    .sync_out(sync_all)
  );

  prmc_pulse_filter #(.WIDTH(NPINS), .MIN_CYC(WAKE_MIN_CYC)) u_filt ( // [R9]
    .pclk(pclk),
    .presetn(presetn),
    .level_in(sync_all[NPINS-1:0]),
    .qualified(wake_q)
  );

  assign nmi_low = sync_all[NPINS];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = setup && !pwrite;
  assign cmd_idle = wr_acc && hit(paddr, CMD_OFS) && pwdata[CMD_IDLE_BIT];
  assign cmd_pd = wr_acc && hit(paddr, CMD_OFS) && pwdata[CMD_POWER_DOWN_INSTRUCTION_BIT];
  // Ready enabled but inactive on last access blocks entry
  assign ready_ok = !ctrl[CTRL_RDYEN_BIT] || (ready_seen == ctrl[CTRL_RDYPOL_BIT]);
  assign any_wake = |wake_q;

  // Register next values
  always_comb begin
    next_ctrl = ctrl;
    next_wake_en = wake_en;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_wake_flag = wake_flag;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (wr_acc && hit(paddr, CTRL_OFS)) begin
      next_ctrl = pwdata[2:0];
    end
    if (wr_acc && hit(paddr, WAKE_EN_OFS)) begin
      next_wake_en = pwdata[NPINS-1:0];
    end
    if (wr_acc && hit(paddr, IRQ_MASK_OFS)) begin
      next_irq_mask = pwdata[EV_NUM-1:0];
    end
    if (wr_acc && hit(paddr, IRQ_STAT_OFS)) begin
      next_irq_stat = irq_stat & ~pwdata[EV_NUM-1:0];
    end
    if (wr_acc && hit(paddr, WAKE_FLAG_OFS)) begin
      next_wake_flag = wake_flag & ~pwdata[NPINS-1:0];
    end
    next_irq_stat = next_irq_stat | ev; // Set wins over clear
    if (state inside {PRMC_PD_INT, PRMC_RESTART}) begin
      next_wake_flag = next_wake_flag | wake_q; // [R12]
    end
    if (setup) begin
      next_pslverr = !(hit(paddr, CTRL_OFS) || hit(paddr, CMD_OFS) || hit(paddr, STATUS_OFS)
        || hit(paddr, IRQ_STAT_OFS) || hit(paddr, IRQ_MASK_OFS) || hit(paddr, WAKE_EN_OFS)
        || hit(paddr, WAKE_FLAG_OFS));
    end
    if (rd_acc) begin
      unique case (paddr)
        CTRL_OFS: next_prdata = {29'h0, ctrl};
        STATUS_OFS: next_prdata = {26'h0, pll_locked, pend_pd, 1'b0, state};
        IRQ_STAT_OFS: next_prdata = {28'h0, irq_stat};
        IRQ_MASK_OFS: next_prdata = {28'h0, irq_mask};
        WAKE_EN_OFS: next_prdata = {24'h0, wake_en};
        WAKE_FLAG_OFS: next_prdata = {24'h0, wake_flag};
        default: next_prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      wake_en <= WAKE_EN_RST;
      irq_mask <= IRQ_MASK_RST;
      irq_stat <= '0;
      wake_flag <= '0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      wake_en <= next_wake_en;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      wake_flag <= next_wake_flag;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      pready <= setup;
    end
  end

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_pend_pd = pend_pd;
    next_lock_cnt = lock_cnt;
    ev = '0;
    unique case (state)
      PRMC_RUN: begin
        if (cmd_idle || cmd_pd) begin // [R1]
          next_pend_pd = cmd_pd;
          next_state = PRMC_DRAIN;
        end
      end
      PRMC_DRAIN: begin
        if (!bus_busy) begin // [R13]
          if (!ready_ok) begin // [R14]
            ev[EV_REFUSE] = 1'b1;
            next_state = PRMC_RUN;
          end else if (!pend_pd) begin
            ev[EV_IDLE_IN] = 1'b1;
            next_state = PRMC_IDLE;
          end else if (ctrl[CTRL_VARIANT_BIT]) begin // [R8]
            ev[EV_PD_IN] = 1'b1;
            next_state = PRMC_PD_INT;
          end else if (nmi_low) begin // [R6] [R7]
            ev[EV_PD_IN] = 1'b1;
            next_state = PRMC_PD_PROT;
          end else begin
            next_state = PRMC_RUN;
          end
        end
      end
      PRMC_IDLE: begin
        if (irq_request) begin // [R3]
          next_state = PRMC_RUN;
        end
      end
      PRMC_PD_PROT: begin
        next_state = PRMC_PD_PROT; // [R5]
      end
      PRMC_PD_INT: begin
        if (any_wake) begin // [R5] [R10]
          ev[EV_WAKE] = 1'b1;
          next_lock_cnt = '0;
          next_state = PRMC_RESTART;
        end
      end
      PRMC_RESTART: begin
        if (pll_locked && lock_cnt == 8'(PLL_LOCK_WAIT_CYC)) begin // [R16]
          next_state = PRMC_RUN;
        end else if (lock_cnt != 8'(PLL_LOCK_WAIT_CYC)) begin
          next_lock_cnt = lock_cnt + 8'h01;
        end
      end
      default: next_state = PRMC_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PRMC_RUN;
      pend_pd <= 1'b0;
      lock_cnt <= 8'h00;
    end else begin
      state <= next_state;
      pend_pd <= next_pend_pd;
      lock_cnt <= next_lock_cnt;
    end
  end

  // ----------------------------------------
  // Clock and power outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en <= 1'b1;
      pll_en <= 1'b1;
      weak_pulldown_en <= 1'b0;
      wake_irq <= '0;
      irq <= 1'b0;
    end else begin
      cpu_clk_en <= next_state == PRMC_RUN; // [R2] [R4]
      periph_clk_en <= next_state inside {PRMC_RUN, PRMC_DRAIN, PRMC_IDLE}; // [R2] [R4]
      osc_en <= next_state != PRMC_PD_INT; // [R8] [R10]
      pll_en <= next_state != PRMC_PD_INT; // [R8] [R10]
      weak_pulldown_en <= (state == PRMC_PD_INT && any_wake) || (weak_pulldown_en && state != PRMC_RUN); // [R10]
      wake_irq <= next_wake_flag & wake_en; // [R11]
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_no_self_entry;
    @(posedge pclk) disable iff (!presetn)
      (state == PRMC_RUN && !cmd_idle && !cmd_pd) |=> state == PRMC_RUN;
  endproperty
  a_no_self_entry: assert property (p_no_self_entry) else $error("mode left run unrequested"); // [R1]

  property p_idle_clocks;
    @(posedge pclk) disable iff (!presetn)
      state == PRMC_IDLE && $past(state) == PRMC_IDLE |-> !cpu_clk_en && periph_clk_en;
  endproperty
  a_idle_clocks: assert property (p_idle_clocks) else $error("idle clock gating wrong"); // [R2]

  property p_idle_exit;
    @(posedge pclk) disable iff (!presetn)
      (state == PRMC_IDLE && irq_request) |=> state == PRMC_RUN;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not left on interrupt"); // [R3]

  property p_pd_clocks;
    @(posedge pclk) disable iff (!presetn)
      $past(state == PRMC_PD_PROT) && state == PRMC_PD_PROT |-> !cpu_clk_en && !periph_clk_en;
  endproperty
  a_pd_clocks: assert property (p_pd_clocks) else $error("power down clocks running"); // [R4]

  property p_prot_stuck;
    @(posedge pclk) disable iff (!presetn)
      state == PRMC_PD_PROT |=> state == PRMC_PD_PROT;
  endproperty
  a_prot_stuck: assert property (p_prot_stuck) else $error("protected power down left"); // [R6]

  property p_nmi_gate;
    @(posedge pclk) disable iff (!presetn)
      (state == PRMC_DRAIN && !bus_busy && pend_pd && !ctrl[CTRL_VARIANT_BIT] && !nmi_low) |=> state == PRMC_RUN;
  endproperty
  a_nmi_gate: assert property (p_nmi_gate) else $error("entered without nmi low"); // [R7]

  property p_wake_osc;
    @(posedge pclk) disable iff (!presetn)
      (state == PRMC_PD_INT && any_wake) |=> osc_en && pll_en && weak_pulldown_en;
  endproperty
  a_wake_osc: assert property (p_wake_osc) else $error("wake did not restart oscillator"); // [R10]

  property p_drain;
    @(posedge pclk) disable iff (!presetn)
      (state == PRMC_DRAIN && bus_busy) |=> state == PRMC_DRAIN;
  endproperty
  a_drain: assert property (p_drain) else $error("entered with bus busy"); // [R13]

  property p_refuse;
    @(posedge pclk) disable iff (!presetn)
      (state == PRMC_DRAIN && !bus_busy && !ready_ok) |=> state == PRMC_RUN && irq_stat[EV_REFUSE];
  endproperty
  a_refuse: assert property (p_refuse) else $error("ready refusal missed"); // [R14]

  property p_lock_hold;
    @(posedge pclk) disable iff (!presetn)
      (state == PRMC_RESTART && !pll_locked) |=> state == PRMC_RESTART;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("restart before lock"); // [R16]
endmodule : prmc_ctrl

// ===== verification/prmc_partner.sv
`timescale 1ns/10ps
module prmc_partner
  import prmc_pkg::*;
#(
  parameter int LOCK_CYC = 40,
  parameter int BUSY_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pll_en,
  input wire logic bus_go,
  input wire logic wake_fire,
  input wire logic [7:0] wake_sel,
  input wire logic [7:0] wake_len,
  output logic bus_busy,
  output logic pll_locked,
  output logic [7:0] wake_pin
);
  int lock_cnt;
  int busy_cnt;
  int wake_cnt;
  logic [7:0] sel;

  // Lock counter, pending bus action and wake pulse length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt <= LOCK_CYC;
      busy_cnt <= 0;
      wake_cnt <= 0;
      sel <= 8'h00;
    end else begin
      lock_cnt <= !pll_en ? 0 : (lock_cnt < LOCK_CYC ? lock_cnt + 1 : lock_cnt);
      busy_cnt <= bus_go ? BUSY_CYC : (busy_cnt > 0 ? busy_cnt - 1 : 0);
      wake_cnt <= wake_fire ? int'(wake_len) : (wake_cnt > 0 ? wake_cnt - 1 : 0);
      if (wake_fire) begin
        sel <= wake_sel;
      end
    end
  end

  // Released wake pins fall back to low
  assign pll_locked = lock_cnt >= LOCK_CYC;
  assign bus_busy = busy_cnt > 0;
  assign wake_pin = wake_cnt > 0 ? sel : 8'h00;
endmodule : prmc_partner

// ===== verification/tb.sv
`timescale 1ns/10ps
module tb
  import prmc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic nmi_n_pin = 1'b1;
  logic irq_request = 1'b0;
  logic ready_seen = 1'b1;
  logic bus_go = 1'b0;
  logic wake_fire = 1'b0;
  logic [7:0] wake_sel = 8'h00;
  logic [7:0] wake_len = 8'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, bus_busy, pll_locked, cpu_clk_en, periph_clk_en;
  logic osc_en, pll_en, weak_pulldown_en, irq;
  logic [7:0] wake_pin, wake_irq;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int i;

  always #4 pclk = ~pclk;

  prmc_ctrl i_prmc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin),
    .nmi_n_pin(nmi_n_pin), .irq_request(irq_request), .bus_busy(bus_busy), .ready_seen(ready_seen),
    .pll_locked(pll_locked), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
    .pll_en(pll_en), .weak_pulldown_en(weak_pulldown_en), .wake_irq(wake_irq), .irq(irq));

  prmc_partner i_prmc_partner (.pclk(pclk), .presetn(presetn), .pll_en(pll_en), .bus_go(bus_go),
    .wake_fire(wake_fire), .wake_sel(wake_sel), .wake_len(wake_len), .bus_busy(bus_busy),
    .pll_locked(pll_locked), .wake_pin(wake_pin));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task test_done;
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task hold(input int n);
    repeat (n) @(negedge pclk);
  endtask : hold

  // One APB transfer; answer taken at the rising edge where pready is high
  task apb(input int w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w[0];
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task until_cpu(input logic v, input int n);
    for (i = 0; i < n && cpu_clk_en !== v; i++) hold(1);
  endtask : until_cpu

  task fire(input logic [7:0] s, input logic [7:0] n);
    @(posedge pclk);
    wake_sel <= s;
    wake_len <= n;
    wake_fire <= 1'b1;
    @(posedge pclk);
    wake_fire <= 1'b0;
  endtask : fire

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task s_reset;
    chk("osc_pll", 2'b11, {osc_en, pll_en});
    chk("pulldown_irq", 2'b00, {weak_pulldown_en, irq});
    apb(0, CTRL_OFS, 0);
    chk("ctrl", CTRL_RST, rd);
    apb(0, IRQ_MASK_OFS, 0);
    chk("mask", IRQ_MASK_RST, rd);
    hold(20);
    chk("cpu_run", 1, cpu_clk_en);
  endtask : s_reset

  task s_idle;
    @(posedge pclk);
    bus_go <= 1'b1;
    @(posedge pclk);
    bus_go <= 1'b0;
    apb(1, CMD_OFS, 32'h1 << CMD_IDLE_BIT);
    hold(5);
    apb(0, STATUS_OFS, 0);
    chk("drain", {1'b1, PRMC_DRAIN}, {periph_clk_en, rd[2:0]});
    hold(20);
    chk("cpu_idle", 2'b01, {cpu_clk_en, periph_clk_en});
    apb(1, IRQ_MASK_OFS, 32'h1 << EV_IDLE_IN);
    hold(2);
    chk("irq_set", 1, irq);
    apb(1, IRQ_STAT_OFS, 32'h1 << EV_IDLE_IN);
    hold(2);
    chk("irq_clr", 0, irq);
    @(posedge pclk);
    irq_request <= 1'b1;
    until_cpu(1'b1, 10);
    chk("cpu_exit", 1, cpu_clk_en);
    @(posedge pclk);
    irq_request <= 1'b0;
  endtask : s_idle

  task s_refuse;
    @(posedge pclk);
    ready_seen <= 1'b0;
    apb(1, CTRL_OFS, 32'h6);
    apb(1, IRQ_MASK_OFS, 32'h1 << EV_REFUSE);
    apb(1, CMD_OFS, 32'h1 << CMD_IDLE_BIT);
    hold(10);
    chk("refuse", 2'b11, {cpu_clk_en, irq});
    apb(1, CTRL_OFS, 32'h2);
    apb(1, CMD_OFS, 32'h1 << CMD_IDLE_BIT);
    until_cpu(1'b0, 40);
    hold(2);
    chk("low_pol", 0, cpu_clk_en);
    @(posedge pclk);
    irq_request <= 1'b1;
    until_cpu(1'b1, 10);
    @(posedge pclk);
    irq_request <= 1'b0;
    ready_seen <= 1'b1;
    apb(1, IRQ_MASK_OFS, 0);
    apb(1, IRQ_STAT_OFS, 32'hf);
  endtask : s_refuse

  task s_prot;
    apb(1, CTRL_OFS, 0);
    apb(1, CMD_OFS, 32'h1 << CMD_POWER_DOWN_INSTRUCTION_BIT);
    hold(10);
    chk("nmi_high", 1, cpu_clk_en);
    @(posedge pclk);
    nmi_n_pin <= 1'b0;
    apb(1, CMD_OFS, 32'h1 << CMD_POWER_DOWN_INSTRUCTION_BIT);
    until_cpu(1'b0, 40);
    hold(2);
    chk("pd_clks", 2'b00, {cpu_clk_en, periph_clk_en});
    apb(0, STATUS_OFS, 0);
    chk("state", PRMC_PD_PROT, rd[2:0]);
    fire(8'hff, 8'h08);
    hold(30);
    chk("prot_hold", 0, cpu_clk_en);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    nmi_n_pin <= 1'b1;
    hold(2);
    chk("prot_exit", 1, cpu_clk_en);
  endtask : s_prot

  task s_intr;
    apb(1, CTRL_OFS, 32'h1);
    apb(1, WAKE_EN_OFS, 32'h1);
    apb(1, CMD_OFS, 32'h1 << CMD_POWER_DOWN_INSTRUCTION_BIT);
    for (i = 0; i < 40 && pll_en !== 1'b0; i++) hold(1);
    chk("frozen", 4'h0, {osc_en, pll_en, cpu_clk_en, periph_clk_en});
    fire(8'h01, 8'h02);
    hold(20);
    chk("short_pulse", 0, osc_en);
    fire(8'h01, WAKE_MIN_CYC[7:0]);
    for (i = 0; i < 20 && osc_en !== 1'b1; i++) hold(1);
    chk("restart", 3'h7, {osc_en, pll_en, weak_pulldown_en});
    chk("cpu_wait_lock", 0, cpu_clk_en);
    until_cpu(1'b1, 100);
    chk("cpu_locked", 1, cpu_clk_en);
    chk("wake_irq_en", 8'h01, wake_irq);
    apb(1, WAKE_FLAG_OFS, 32'hff);
    apb(1, WAKE_EN_OFS, 0);
    apb(1, CMD_OFS, 32'h1 << CMD_POWER_DOWN_INSTRUCTION_BIT);
    for (i = 0; i < 40 && pll_en !== 1'b0; i++) hold(1);
    fire(8'h04, WAKE_MIN_CYC[7:0]);
    until_cpu(1'b1, 150);
    chk("wake_irq_dis", 8'h00, {wake_irq, ~cpu_clk_en});
    apb(0, WAKE_FLAG_OFS, 0);
    chk("flag_kept", 32'h4, rd);
    apb(1, WAKE_FLAG_OFS, 32'h4);
    apb(0, WAKE_FLAG_OFS, 0);
    chk("flag_clr", 0, rd);
    apb(0, 8'h1c, 0);
    chk("unmapped_err", 1, er);
    chk("unmapped_rd", 0, rd);
  endtask : s_intr

  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    s_reset();
    s_idle();
    s_refuse();
    s_prot();
    s_intr();
    test_done();
  end
endmodule : tb
